/* File: src/sfr_cmd_front.sv */
// Purpose: command front end: 4-byte lock bits, interface/CRC codes,
//   discovery and general purpose reads, address mode, software reset
// Assumes: serial clock, select and data pins are asynchronous to clk_sys
// Notes: serial clock must be slower than clk_sys/4 after synchronising
//
// Notes on behaviour
// [R1] command bits use protocol line count
// [R2] extended protocol is plain SPI plus commands
// [R3] E0h: four address bytes, no dummy
// [R4] E1h: four address bytes then data
// [R5] 9Bh activates; 9Bh then 27h carries CRC
// [R6] discovery read always three address bytes
// [R7] discovery read always eight dummy cycles
// [R8] three-or-four address follows address mode
// [R9] configured dummy count overrides factory default
// [R10] general register read always eight dummies
// [R11] general register: 64 bytes, then 00h
// [R12] host sends write enable first
// [R13] host lowers select then sends code
// [R14] host sends 66h then 99h separately
// [R15] host waits deselect time between pair
// [R16] select rise after 99h starts reset
// [R17] host waits reselect time after reset
// [R18] host should leave execute-in-place first
// [R19] reset restores volatile state from nonvolatile
// [R20] reset aborts running or suspended operation
// [R21] reset done when flag bit 7 read
// [R22] reset enable refused during register writes
// [R23] reset codes work in every protocol
// [R24] B7h enters, E9h leaves 4-byte mode
// [R25] reset memory needs directly preceding enable
`timescale 1ns/100ps
`default_nettype none
module sfr_cmd_front
  import sfr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sclkPin,
  input wire logic chipSelPin_n,
  input wire logic [3:0] ioPinIn,
  output logic [3:0] ioPinOut,
  output logic [3:0] ioPinOe_n,
  input wire sfr_proto_type proto,
  input wire logic dtrEn,
  input wire logic nvAddr4,
  input wire logic [4:0] dummyCfg,
  input wire logic statusWrBusy,
  input wire logic nvcfgWrBusy,
  input wire logic opBusy,
  input wire logic [7:0] flagStatus,
  input wire logic [7:0] rdData,
  input wire logic gprWrEn,
  input wire logic [GPR_AW-1:0] gprWrAddr,
  input wire logic [7:0] gprWrData,
  output logic addr4Mode,
  output var sfr_rd_type rdReq,
  output var sfr_wr_type wrEvt,
  output logic ifActPulse,
  output logic swResetPulse,
  output logic opAbortPulse,
  output logic resetBusy,
  output logic resetArmed
);
  logic [5:0] pinSync1_ff;
  logic [5:0] pinSync2_ff;
  logic [5:0] pinPrev_ff;
  logic sclkRise, sclkFall, csActive, csRise, sampleEdge;
  logic [3:0] ioS;
  logic [2:0] lines;
  logic [3:0] oeMask;
  sfr_state_type state_ff, decState, afterAddr;
  logic [3:0] bitCnt_ff, nxtBitCnt;
  logic [7:0] inSh_ff, nxtSh, cmd_ff;
  logic cmdDone_ff, extra_ff, crcPair_ff, isRead_ff, byteDone, byteState;
  logic [31:0] addr_ff, curAddr, nxtOutAddr;
  logic [2:0] addrLeft_ff, decAddr;
  logic [4:0] dummyLeft_ff, dummyTotal_ff, decDummy, otpDummy;
  logic decRead, frameCmd, rstEnOk, fireReset, flagReadyLoad;
  logic [7:0] outSh_ff, srcByte, gprQ, shifted;
  logic [3:0] outLeft_ff;
  logic [31:0] outAddr_ff;
  logic outStarted_ff, outLoad, outShift;

  function automatic logic [3:0] laneOut(input logic [7:0] b,
                                         input logic [2:0] n);
    logic [3:0] r;
    r = b[7:4];
    if (n == LINES_1)
      r = {2'h0, b[7], 1'h0};
    else if (n == LINES_2)
      r = {2'h0, b[7:6]};
    return r;
  endfunction : laneOut

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pinSync1_ff <= PIN_IDLE;
      pinSync2_ff <= PIN_IDLE;
      pinPrev_ff <= PIN_IDLE;
    end
    else
    begin
      pinSync1_ff <= {sclkPin, chipSelPin_n, ioPinIn};
      pinSync2_ff <= pinSync1_ff;
      pinPrev_ff <= pinSync2_ff;
    end
  end

  assign ioS = pinSync2_ff[3:0];
  assign csActive = !pinSync2_ff[4];
  assign csRise = pinSync2_ff[4] && !pinPrev_ff[4];
  assign sclkRise = pinSync2_ff[5] && !pinPrev_ff[5];
  assign sclkFall = !pinSync2_ff[5] && pinPrev_ff[5];
  // double transfer rate takes input bits on both edges
  assign sampleEdge = sclkRise || (dtrEn && sclkFall); // [R23]

  always_comb
  begin
    lines = LINES_1; // [R2]
    oeMask = OE_N_X1;
    case (proto)
      PROTO_DUAL:
      begin
        lines = LINES_2; // [R1]
        oeMask = OE_N_X2;
      end
      PROTO_QUAD:
      begin
        lines = LINES_4; // [R1]
        oeMask = OE_N_X4;
      end
      default:
      begin
        lines = LINES_1;
        oeMask = OE_N_X1;
      end
    endcase
  end

  always_comb
  begin
    nxtSh = {inSh_ff[6:0], ioS[0]};
    if (lines == LINES_2)
      nxtSh = {inSh_ff[5:0], ioS[1:0]};
    else if (lines == LINES_4)
      nxtSh = {inSh_ff[3:0], ioS};
  end

  assign nxtBitCnt = bitCnt_ff + {1'b0, lines};
  assign byteState = (state_ff == S_CMD) || (state_ff == S_ADDR) ||
                     (state_ff == S_DIN) || (state_ff == S_PAIR);
  assign byteDone = csActive && sampleEdge && byteState &&
                    (nxtBitCnt >= BYTE_BITS);
  assign otpDummy = (dummyCfg != 5'h00) ? dummyCfg : // [R9]
                    ((lines == LINES_4) ? DUMMY_OTP_QUAD : DUMMY_OTP_DEF);

  always_comb
  begin
    decAddr = addr4Mode ? ADDR_4B : ADDR_3B; // [R8]
    decDummy = 5'h00;
    decRead = 1'b0;
    decState = S_IGNORE;
    case (nxtSh)
      CMD_RD_LOCK4:
      begin
        decAddr = ADDR_4B; // [R3]
        decRead = 1'b1;
        decState = S_ADDR;
      end
      CMD_WR_LOCK4:
      begin
        decAddr = ADDR_4B; // [R4]
        decState = S_ADDR;
      end
      CMD_RD_LOCK:
      begin
        decRead = 1'b1;
        decState = S_ADDR;
      end
      CMD_WR_LOCK:
        decState = S_ADDR;
      CMD_SFDP:
      begin
        decAddr = ADDR_3B; // [R6]
        decDummy = DUMMY_FIXED; // [R7]
        decRead = 1'b1;
        decState = S_ADDR;
      end
      CMD_OTP_RD:
      begin
        decDummy = otpDummy; // [R9]
        decRead = 1'b1;
        decState = S_ADDR;
      end
      CMD_GPRR:
      begin
        decDummy = DUMMY_FIXED; // [R10]
        decRead = 1'b1;
        decState = S_DUMMY;
      end
      CMD_FLAG_RD:
      begin
        decRead = 1'b1;
        decState = S_DOUT;
      end
      CMD_IF_ACT:
        decState = S_PAIR; // [R5]
      default:
        decState = S_IGNORE;
    endcase
  end

  always_comb
  begin
    afterAddr = S_DIN;
    if (dummyTotal_ff != 5'h00)
      afterAddr = S_DUMMY;
    else if (isRead_ff)
      afterAddr = S_DOUT;
  end

  // frame sequencer; select high always returns to the command phase
  always_ff @(posedge clk_sys)
  begin
    if (rst || !csActive)
    begin
      state_ff <= S_CMD;
      bitCnt_ff <= 4'h0;
      inSh_ff <= 8'h00;
      cmdDone_ff <= 1'b0;
      extra_ff <= 1'b0;
      crcPair_ff <= 1'b0;
      addr_ff <= 32'h0;
      addrLeft_ff <= 3'h0;
      dummyLeft_ff <= 5'h00;
      if (rst)
      begin
        cmd_ff <= 8'h00;
        dummyTotal_ff <= 5'h00;
        isRead_ff <= 1'b0;
      end
    end
    else
    begin
      if (sampleEdge && byteState)
      begin
        inSh_ff <= nxtSh;
        bitCnt_ff <= byteDone ? 4'h0 : nxtBitCnt;
      end
      if (byteDone)
      begin
        case (state_ff)
          S_CMD:
          begin
            cmd_ff <= nxtSh;
            cmdDone_ff <= 1'b1;
            addrLeft_ff <= decAddr;
            dummyTotal_ff <= decDummy;
            dummyLeft_ff <= decDummy;
            isRead_ff <= decRead;
            state_ff <= decState;
          end
          S_ADDR:
          begin
            addr_ff <= {addr_ff[23:0], nxtSh};
            addrLeft_ff <= addrLeft_ff - 3'h1;
            if (addrLeft_ff == 3'h1)
              state_ff <= afterAddr;
          end
          S_PAIR:
          begin
            if (nxtSh == CMD_CRC)
            begin
              crcPair_ff <= 1'b1; // [R5]
              state_ff <= S_DIN;
            end
            else
            begin
              extra_ff <= 1'b1;
              state_ff <= S_IGNORE;
            end
          end
          default:
            addr_ff <= addr_ff + 32'h1;
        endcase
      end
      else if (state_ff == S_DUMMY && sclkRise)
      begin
        dummyLeft_ff <= dummyLeft_ff - 5'h01;
        if (dummyLeft_ff == 5'h01)
          state_ff <= S_DOUT;
      end
      else if (state_ff == S_IGNORE && sampleEdge)
        extra_ff <= 1'b1;
    end
  end

  // received data bytes: lock bit writes and CRC bytes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wrEvt <= '0;
      ifActPulse <= 1'b0;
    end
    else
    begin
      wrEvt.valid <= byteDone && (state_ff == S_DIN); // [R4]
      wrEvt.cmd <= crcPair_ff ? CMD_CRC : cmd_ff;
      wrEvt.addr <= addr_ff;
      wrEvt.data <= nxtSh;
      ifActPulse <= csRise && (state_ff == S_PAIR) && !extra_ff; // [R5]
    end
  end

  // commands act on the select rise, only when no stray bits followed
  assign frameCmd = csRise && cmdDone_ff && !extra_ff;
  assign rstEnOk = frameCmd && (cmd_ff == CMD_RST_EN) &&
                   !statusWrBusy && !nvcfgWrBusy; // [R22]
  assign fireReset = frameCmd && (cmd_ff == CMD_RST_MEM) &&
                     resetArmed; // [R16]

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      resetArmed <= 1'b0;
    else if (csRise && cmdDone_ff)
      resetArmed <= rstEnOk; // [R25]
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      swResetPulse <= 1'b0;
      opAbortPulse <= 1'b0;
    end
    else
    begin
      swResetPulse <= fireReset; // [R19]
      opAbortPulse <= fireReset && opBusy; // [R20]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst || fireReset)
      addr4Mode <= nvAddr4; // [R19]
    else if (frameCmd && cmd_ff == CMD_ENTER_A4)
      addr4Mode <= 1'b1; // [R24]
    else if (frameCmd && cmd_ff == CMD_EXIT_A4)
      addr4Mode <= 1'b0; // [R24]
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      resetBusy <= 1'b0;
    else if (fireReset)
      resetBusy <= 1'b1;
    else if (flagReadyLoad)
      resetBusy <= 1'b0; // [R21]
  end

  // output path: bits change on serial clock falls
  assign curAddr = outStarted_ff ? outAddr_ff : addr_ff;
  // discovery table wraps inside its own space
  // inner cast keeps the sum at table width so it wraps
  assign nxtOutAddr = (cmd_ff == CMD_SFDP) ?
                      32'(SFDP_AW'(curAddr[SFDP_AW-1:0] + 1'b1)) :
                      curAddr + 32'h1;
  assign outLoad = csActive && sclkFall && (state_ff == S_DOUT) &&
                   (outLeft_ff == 4'h0);
  assign outShift = csActive && sclkFall && (state_ff == S_DOUT) &&
                    (outLeft_ff != 4'h0);
  assign shifted = outSh_ff << lines;

  always_comb
  begin
    srcByte = rdData;
    if (cmd_ff == CMD_GPRR)
      srcByte = (curAddr >= 32'(GPR_BYTES)) ? GPR_PAD : gprQ; // [R11]
    else if (cmd_ff == CMD_FLAG_RD)
      srcByte = flagStatus;
  end

  assign flagReadyLoad = outLoad && (cmd_ff == CMD_FLAG_RD) &&
                         srcByte[FLAG_READY_POS]; // [R21]

  always_ff @(posedge clk_sys)
  begin
    if (rst || state_ff != S_DOUT || !csActive)
    begin
      outSh_ff <= 8'h00;
      outLeft_ff <= 4'h0;
      outAddr_ff <= 32'h0;
      outStarted_ff <= 1'b0;
      ioPinOut <= 4'h0;
      ioPinOe_n <= OE_N_OFF;
    end
    else if (outLoad)
    begin
      outSh_ff <= srcByte;
      outLeft_ff <= BYTE_BITS - {1'b0, lines};
      outAddr_ff <= nxtOutAddr;
      outStarted_ff <= 1'b1;
      ioPinOut <= laneOut(srcByte, lines);
      ioPinOe_n <= oeMask;
    end
    else if (outShift)
    begin
      outSh_ff <= shifted;
      outLeft_ff <= outLeft_ff - {1'b0, lines};
      ioPinOut <= laneOut(shifted, lines);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdReq <= '0;
    else
    begin
      rdReq.active <= csActive && (state_ff == S_DOUT);
      rdReq.cmd <= cmd_ff;
      rdReq.addr <= curAddr;
    end
  end

  sfr_gpr_mem u_gpr_mem (
    .clk_sys(clk_sys),
    .rst(rst),
    .wrEn(gprWrEn),
    .wrAddr(gprWrAddr),
    .wrData(gprWrData),
    .rdAddr(curAddr[GPR_AW-1:0]),
    .rdData(gprQ)
  );

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  AST_RESET_NEEDS_ENABLE: assert property ( // [R25]
    swResetPulse |-> $past(resetArmed) && $past(cmd_ff) == CMD_RST_MEM)
    else $error("reset fired without a preceding reset enable");
  AST_RESET_ON_CS_RISE: assert property ( // [R16]
    swResetPulse |-> $past(csRise) && !resetArmed)
    else $error("reset not tied to select rise");
  AST_ENABLE_REJECT_BUSY: assert property ( // [R22]
    (csRise && cmdDone_ff && (statusWrBusy || nvcfgWrBusy)) |=> !resetArmed)
    else $error("reset enable accepted during register write");
  AST_ABORT_ON_RESET: assert property ( // [R20]
    opAbortPulse |-> swResetPulse && $past(opBusy))
    else $error("abort not matched to reset with busy operation");
  AST_SFDP_ADDR3: assert property ( // [R6]
    (byteDone && state_ff == S_CMD && nxtSh == CMD_SFDP)
      |=> addrLeft_ff == ADDR_3B)
    else $error("discovery read address count wrong");
  AST_SFDP_DUMMY8: assert property ( // [R7]
    (state_ff == S_DUMMY && cmd_ff == CMD_SFDP) |-> dummyTotal_ff == 5'h08)
    else $error("discovery read dummy count wrong");
  AST_GPRR_DUMMY8: assert property ( // [R10]
    (byteDone && state_ff == S_CMD && nxtSh == CMD_GPRR)
      |=> state_ff == S_DUMMY && dummyLeft_ff == 5'h08)
    else $error("general register read dummy count wrong");
  AST_ADDR_MODE_COUNT: assert property ( // [R8]
    (byteDone && state_ff == S_CMD && nxtSh == CMD_RD_LOCK)
      |=> addrLeft_ff == ($past(addr4Mode) ? 3'h4 : 3'h3))
    else $error("address count ignores address mode");
  AST_LOCK4_ADDR4: assert property ( // [R3]
    (byteDone && state_ff == S_CMD && nxtSh == CMD_RD_LOCK4)
      |=> addrLeft_ff == 3'h4 && dummyTotal_ff == 5'h00)
    else $error("4-byte lock read framing wrong");
  AST_GPR_PAD: assert property ( // [R11]
    (outLoad && cmd_ff == CMD_GPRR && curAddr >= 32'd64)
      |=> outSh_ff == 8'h00)
    else $error("general register read past end not zero");
  AST_A4_ENTER: assert property ( // [R24]
    (frameCmd && cmd_ff == CMD_ENTER_A4) |=> addr4Mode)
    else $error("4-byte mode not entered");
  AST_RESTORE_A4: assert property ( // [R19]
    swResetPulse |-> addr4Mode == $past(nvAddr4) && resetBusy)
    else $error("address mode not restored on reset");
  AST_BUSY_UNTIL_FLAG: assert property ( // [R21]
    (resetBusy && !flagReadyLoad) |=> resetBusy)
    else $error("reset busy dropped without flag read");

  COV_RESET_PAIR: cover property (swResetPulse);
  COV_ABORT: cover property (opAbortPulse);
  COV_GPR_OVERRUN: cover property (outLoad && curAddr >= 32'd64);
  COV_CRC_BYTE: cover property (wrEvt.valid && wrEvt.cmd == CMD_CRC);
endmodule : sfr_cmd_front
`default_nettype wire

/* File: src/sfr_gpr_mem.sv */
// Purpose: 64-byte general purpose read register storage
// Assumes: written by device-internal logic, read one byte per load
// Notes: read data is registered, one cycle after the address
`timescale 1ns/100ps
`default_nettype none
module sfr_gpr_mem
  import sfr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wrEn,
  input wire logic [GPR_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [GPR_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem_ff [GPR_BYTES];

  always_ff @(posedge clk_sys)
  begin
    if (wrEn)
    begin
      mem_ff[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdData <= GPR_PAD;
    end
    else
    begin
      rdData <= mem_ff[rdAddr];
    end
  end
endmodule : sfr_gpr_mem
`default_nettype wire

/* File: src/sfr_pkg.sv */
// Purpose: shared constants and types for the serial flash command front end
// Assumes: one system clock; pins are sampled through two flip-flops
// Notes: opcodes not shown with the 4-byte and reset group are plain defaults
package sfr_pkg;
  localparam logic [7:0] CMD_RD_LOCK4 = 8'hE0;
  localparam logic [7:0] CMD_WR_LOCK4 = 8'hE1;
  localparam logic [7:0] CMD_RD_LOCK = 8'hE8;
  localparam logic [7:0] CMD_WR_LOCK = 8'hE5;
  localparam logic [7:0] CMD_IF_ACT = 8'h9B;
  localparam logic [7:0] CMD_CRC = 8'h27;
  localparam logic [7:0] CMD_SFDP = 8'h5A;
  localparam logic [7:0] CMD_GPRR = 8'h96;
  localparam logic [7:0] CMD_OTP_RD = 8'h4B;
  localparam logic [7:0] CMD_FLAG_RD = 8'h70;
  localparam logic [7:0] CMD_ENTER_A4 = 8'hB7;
  localparam logic [7:0] CMD_EXIT_A4 = 8'hE9;
  localparam logic [7:0] CMD_RST_EN = 8'h66;
  localparam logic [7:0] CMD_RST_MEM = 8'h99;

  localparam logic [2:0] ADDR_3B = 3'h3;
  localparam logic [2:0] ADDR_4B = 3'h4;
  localparam logic [4:0] DUMMY_FIXED = 5'h08;
  localparam logic [4:0] DUMMY_OTP_DEF = 5'h08;
  localparam logic [4:0] DUMMY_OTP_QUAD = 5'h0A;

  localparam int GPR_BYTES = 64;
  localparam int GPR_AW = 6;
  localparam int SFDP_AW = 11;
  localparam logic [7:0] GPR_PAD = 8'h00;
  localparam int FLAG_READY_POS = 7;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LINES_1 = 3'h1;
  localparam logic [2:0] LINES_2 = 3'h2;
  localparam logic [2:0] LINES_4 = 3'h4;
  localparam logic [3:0] OE_N_X1 = 4'hD;
  localparam logic [3:0] OE_N_X2 = 4'hC;
  localparam logic [3:0] OE_N_X4 = 4'h0;
  localparam logic [3:0] OE_N_OFF = 4'hF;
  localparam logic [5:0] PIN_IDLE = 6'h10;

  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} sfr_proto_type;

  typedef enum logic [2:0] {
    S_CMD, S_ADDR, S_DUMMY, S_DIN, S_DOUT, S_PAIR, S_IGNORE
  } sfr_state_type;

  typedef struct packed {
    logic active;
    logic [7:0] cmd;
    logic [31:0] addr;
  } sfr_rd_type;

  typedef struct packed {
    logic valid;
    logic [7:0] cmd;
    logic [31:0] addr;
    logic [7:0] data;
  } sfr_wr_type;
endpackage : sfr_pkg

/* File: tb/sfr_host_model.sv */
// Purpose: host controller model driving select, serial clock and data
// Assumes: serial clock half period is four clk_sys cycles (80 ns)
// Notes: released data lines show the inverse of the last driven value
`timescale 1ns/100ps
`default_nettype none
module sfr_host_model
  import sfr_pkg::*;
#(
  parameter int DESEL_CLK = 12
)
(
  input wire logic clk_sys,
  input wire sfr_proto_type proto,
  input wire logic [3:0] ioPinOut,
  input wire logic [3:0] ioPinOe_n,
  output logic sclkPin,
  output logic chipSelPin_n,
  output logic [3:0] ioPinIn
);
  logic [3:0] hostDrv;
  logic hostEn;
  int w;
  // wire level from both parties' enables; nobody driving shows ~last
  assign ioPinIn = (~ioPinOe_n & ioPinOut) |
    (ioPinOe_n & (hostEn ? hostDrv : ~hostDrv));
  always_comb
  begin
    w = (proto == PROTO_QUAD) ? 4 : (proto == PROTO_DUAL) ? 2 : 1;
  end
  initial
  begin
    sclkPin = 1'b0;
    chipSelPin_n = 1'b1;
    hostDrv = 4'h0;
    hostEn = 1'b0;
  end
  task automatic waitClk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : waitClk
  // never in execute-in-place mode, so a reset pair is always legal
  task automatic sel();
    waitClk(4);
    chipSelPin_n = 1'b0;
    waitClk(4);
  endtask : sel
  // deselect long enough for pair spacing and post-reset reselect
  task automatic desel();
    waitClk(4);
    chipSelPin_n = 1'b1;
    hostEn = 1'b0;
    waitClk(DESEL_CLK);
  endtask : desel
  task automatic sendByte(input logic [7:0] b);
    for (int i = 0; i < 8; i += w)
    begin
      hostEn = 1'b1;
      hostDrv = 4'((b >> (8 - i - w)) & ((1 << w) - 1));
      waitClk(4);
      sclkPin = 1'b1;
      waitClk(4);
      sclkPin = 1'b0;
    end
  endtask : sendByte
  // bits move on both serial clock edges, each set half a phase early
  task automatic sendByteDtr(input logic [7:0] b);
    for (int i = 0; i < 8; i += w)
    begin
      hostEn = 1'b1;
      hostDrv = 4'((b >> (8 - i - w)) & ((1 << w) - 1));
      waitClk(2);
      sclkPin = ~sclkPin;
      waitClk(2);
    end
  endtask : sendByteDtr
  task automatic dummy(input int n);
    hostEn = 1'b0;
    repeat (n)
    begin
      waitClk(4);
      sclkPin = 1'b1;
      waitClk(4);
      sclkPin = 1'b0;
    end
  endtask : dummy
  task automatic recvByte(output logic [7:0] b);
    logic [3:0] bits;
    b = 8'h00;
    hostEn = 1'b0;
    for (int i = 0; i < 8; i += w)
    begin
      waitClk(4);
      sclkPin = 1'b1;
      waitClk(2);
      bits = (w == 1) ? {3'b0, ioPinIn[1]} : ioPinIn & 4'((1 << w) - 1);
      b = (b << w) | {4'h0, bits};
      waitClk(2);
      sclkPin = 1'b0;
    end
  endtask : recvByte
endmodule : sfr_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: self-checking bench for the command front end
// Assumes: external read data is a pure function of the read address
// Notes: double transfer rate input is exercised on the reset pair only
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, ac); \
  end end
module tb_top
  import sfr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sfr_proto_type proto = PROTO_EXT;
  logic nvAddr4 = 1'b0, statusWrBusy = 1'b0, nvcfgWrBusy = 1'b0;
  logic opBusy = 1'b0, gprWrEn = 1'b0, dtrEn = 1'b0;
  // write enable is decoded outside this block; stand-in code
  localparam logic [7:0] WREN_CODE = 8'h00;
  logic [4:0] dummyCfg = 5'h00;
  logic [7:0] flagStatus = 8'h00, gprWrData = 8'h00, rdData, b;
  logic [GPR_AW-1:0] gprWrAddr = '0;
  logic sclkPin, chipSelPin_n, addr4Mode, ifActPulse, swResetPulse;
  logic opAbortPulse, resetBusy, resetArmed;
  logic [3:0] ioPinIn, ioPinOut, ioPinOe_n;
  sfr_rd_type rdReq;
  sfr_wr_type wrEvt, lastWr;
  int err_count = 0, check_count = 0, cycles = 0;
  int rstCnt = 0, abortCnt = 0, actCnt = 0, n0, a0;
  always #10 clk_sys = ~clk_sys;
  always_comb rdData = rdReq.addr[7:0] ^ 8'h5A;
  sfr_host_model hostModel (.clk_sys(clk_sys), .proto(proto),
    .ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n), .sclkPin(sclkPin),
    .chipSelPin_n(chipSelPin_n), .ioPinIn(ioPinIn));
  sfr_cmd_front DUT (.clk_sys(clk_sys), .rst(rst), .sclkPin(sclkPin),
    .chipSelPin_n(chipSelPin_n), .ioPinIn(ioPinIn), .ioPinOut(ioPinOut),
    .ioPinOe_n(ioPinOe_n), .proto(proto), .dtrEn(dtrEn), .nvAddr4(nvAddr4),
    .dummyCfg(dummyCfg), .statusWrBusy(statusWrBusy),
    .nvcfgWrBusy(nvcfgWrBusy), .opBusy(opBusy), .flagStatus(flagStatus),
    .rdData(rdData), .gprWrEn(gprWrEn), .gprWrAddr(gprWrAddr),
    .gprWrData(gprWrData), .addr4Mode(addr4Mode), .rdReq(rdReq),
    .wrEvt(wrEvt), .ifActPulse(ifActPulse), .swResetPulse(swResetPulse),
    .opAbortPulse(opAbortPulse), .resetBusy(resetBusy),
    .resetArmed(resetArmed));
  // pulses are one cycle wide, so they are counted rather than sampled
  always @(posedge clk_sys)
  begin
    cycles++;
    rstCnt += swResetPulse;
    abortCnt += opAbortPulse;
    actCnt += ifActPulse;
    if (wrEvt.valid) lastWr = wrEvt;
    if (cycles == 60000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic cmd1(input logic [7:0] c);
    hostModel.sel();
    hostModel.sendByte(c);
    hostModel.desel();
  endtask : cmd1
  task automatic rdSeq(input logic [7:0] c, input int na,
    input logic [31:0] a, input int nd, input int n);
    logic [31:0] ad;
    hostModel.sel();
    hostModel.sendByte(c);
    for (int k = na - 1; k >= 0; k--) hostModel.sendByte(a[8*k +: 8]);
    hostModel.dummy(nd);
    for (int i = 0; i < n; i++)
    begin
      hostModel.recvByte(b);
      ad = a + 32'(i);
      `CHK("rdact", 1'b1, rdReq.active);
      `CHK("rdcmd", c, rdReq.cmd);
      `CHK("rddata", ad[7:0] ^ 8'h5A, b);
    end
    hostModel.desel();
  endtask : rdSeq
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("oe", OE_N_OFF, ioPinOe_n);
    `CHK("armed", 1'b0, resetArmed);
    `CHK("a4", 1'b0, addr4Mode);
    $display("test reset_values done");
    cmd1(CMD_ENTER_A4);
    `CHK("a4", 1'b1, addr4Mode);
    rdSeq(CMD_SFDP, 3, 32'h345, 8, 2);
    rdSeq(CMD_RD_LOCK, 4, 32'h01020304, 0, 1);
    dummyCfg = 5'h04;
    rdSeq(CMD_OTP_RD, 4, 32'h10, 4, 1);
    dummyCfg = 5'h00;
    cmd1(CMD_EXIT_A4);
    `CHK("a4", 1'b0, addr4Mode);
    rdSeq(CMD_RD_LOCK, 3, 32'h0A0B0C, 0, 1);
    rdSeq(CMD_OTP_RD, 3, 32'h20, 8, 1);
    $display("test addr_dummy done");
    for (int p = 0; p < 3; p++)
    begin
      proto = sfr_proto_type'(p);
      rdSeq(CMD_RD_LOCK4, 4, 32'hA0B0C0D0 + p, 0, 2);
      cmd1(CMD_ENTER_A4);
      opBusy = (p == 2);
      n0 = rstCnt;
      a0 = abortCnt;
      cmd1(CMD_RST_EN);
      `CHK("armed", 1'b1, resetArmed);
      cmd1(CMD_RST_MEM);
      opBusy = 1'b0;
      `CHK("rstpulse", n0 + 1, rstCnt);
      `CHK("abort", a0 + (p == 2), abortCnt);
      `CHK("a4", 1'b0, addr4Mode);
      `CHK("busy", 1'b1, resetBusy);
    end
    proto = PROTO_EXT;
    $display("test reset_pair done");
    for (int f = 0; f < 2; f++)
    begin
      flagStatus = f ? 8'h80 : 8'h00;
      hostModel.sel();
      hostModel.sendByte(CMD_FLAG_RD);
      hostModel.recvByte(b);
      hostModel.desel();
      `CHK("flag", flagStatus, b);
      `CHK("busy", f == 0, resetBusy);
    end
    n0 = rstCnt;
    cmd1(CMD_ENTER_A4);
    cmd1(CMD_RST_EN);
    cmd1(CMD_ENTER_A4);
    `CHK("armed", 1'b0, resetArmed);
    cmd1(CMD_RST_MEM);
    cmd1(CMD_RST_MEM);
    `CHK("rstpulse", n0, rstCnt);
    `CHK("a4", 1'b1, addr4Mode);
    statusWrBusy = 1'b1;
    cmd1(CMD_RST_EN);
    `CHK("armed", 1'b0, resetArmed);
    statusWrBusy = 1'b0;
    nvcfgWrBusy = 1'b1;
    cmd1(CMD_RST_EN);
    `CHK("armed", 1'b0, resetArmed);
    nvcfgWrBusy = 1'b0;
    $display("test reset_refuse done");
    a0 = actCnt;
    cmd1(CMD_IF_ACT);
    `CHK("ifact", a0 + 1, actCnt);
    hostModel.sel();
    hostModel.sendByte(CMD_IF_ACT);
    hostModel.sendByte(CMD_CRC);
    hostModel.sendByte(8'hC3);
    `CHK("crc", {1'b1, CMD_CRC, 8'hC3}, {lastWr[48:40], lastWr[7:0]});
    hostModel.desel();
    `CHK("ifact", a0 + 1, actCnt);
    cmd1(WREN_CODE);
    hostModel.sel();
    hostModel.sendByte(CMD_WR_LOCK4);
    for (int k = 0; k < 4; k++) hostModel.sendByte(k == 2 ? 8'h01 : 8'h00);
    hostModel.sendByte(8'h5C);
    `CHK("wr", {1'b1, CMD_WR_LOCK4, 32'h100, 8'h5C}, lastWr);
    hostModel.sendByte(8'hA7);
    `CHK("wr", {1'b1, CMD_WR_LOCK4, 32'h101, 8'hA7}, lastWr);
    hostModel.desel();
    $display("test write_crc done");
    for (int i = 0; i < GPR_BYTES; i++)
    begin
      @(negedge clk_sys);
      gprWrEn = 1'b1;
      gprWrAddr = GPR_AW'(i);
      gprWrData = 8'(i + 1);
    end
    @(negedge clk_sys);
    gprWrEn = 1'b0;
    hostModel.sel();
    hostModel.sendByte(CMD_GPRR);
    hostModel.dummy(8);
    for (int i = 0; i < GPR_BYTES + 2; i++)
    begin
      hostModel.recvByte(b);
      `CHK("gpr", i < GPR_BYTES ? 8'(i + 1) : GPR_PAD, b);
    end
    hostModel.desel();
    $display("test gpr done");
    dtrEn = 1'b1;
    n0 = rstCnt;
    hostModel.sel();
    hostModel.sendByteDtr(CMD_RST_EN);
    hostModel.desel();
    `CHK("armed", 1'b1, resetArmed);
    hostModel.sel();
    hostModel.sendByteDtr(CMD_RST_MEM);
    hostModel.desel();
    `CHK("rstpulse", n0 + 1, rstCnt);
    dtrEn = 1'b0;
    $display("test dtr_reset done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
